// File: include/cbc_pkg.sv
// cbc_pkg: constants, register map and build options of the counter
// assumes: included before any other cbc file in compile order
package cbc_pkg;

    // ************************************************
    // widths
    // ************************************************
    localparam int CNT_WIDTH = 32;
    localparam int CNT_WIDTH_MAX = 64;
    localparam int AXI_ADDR_W = 5;
    localparam int AXI_DATA_W = 32;
    localparam int AXI_STRB_W = AXI_DATA_W / 8;

    // ************************************************
    // register map, byte addresses
    // ************************************************
    localparam logic [AXI_ADDR_W-1:0] OFF_CTRL = 5'h00;
    localparam logic [AXI_ADDR_W-1:0] OFF_LOAD_DATA = 5'h04;
    localparam logic [AXI_ADDR_W-1:0] OFF_VALUE = 5'h08;
    localparam logic [AXI_ADDR_W-1:0] OFF_STATUS = 5'h0C;
    localparam logic [AXI_ADDR_W-1:0] OFF_CONFIG = 5'h10;

    // ************************************************
    // field positions
    // ************************************************
    localparam int CTRL_UP_BIT = 0;
    localparam int CTRL_LOAD_BIT = 1;
    localparam int CTRL_RESTART_BIT = 2;
    localparam int STAT_TERM_BIT = 0;
    localparam int STAT_DIR_BIT = 1;
    localparam int CFG_LIMITED_BIT = 0;
    localparam int CFG_SIGNED_BIT = 1;
    localparam int CFG_LOAD_BIT = 2;
    localparam int CFG_DIR_LSB = 3;

    // ************************************************
    // responses and reset values
    // ************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic UP_DIR_RST = 1'b1;
    localparam logic [CNT_WIDTH-1:0] START_DEF = 32'h0000_0000;
    localparam logic [CNT_WIDTH-1:0] TERMINAL_DEF = 32'h0000_000F;
    localparam logic [CNT_WIDTH-1:0] STEP_DEF = 32'h0000_0001;

    // ************************************************
    // build options
    // ************************************************
    typedef enum logic [1:0] {
        CBC_FREE = 2'b01,
        CBC_LIMITED = 2'b10
    } cbc_kind_t;

    typedef enum logic [2:0] {
        CBC_UP = 3'b001,
        CBC_DOWN = 3'b010,
        CBC_UPDOWN = 3'b100
    } cbc_dir_t;

endpackage

// File: include/cbc_core_if.sv
// cbc_core_if: control and value signals between register file and core
// assumes: cbc_pkg compiled first; one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface cbc_core_if;
    import cbc_pkg::*;
    logic up_dir;
    logic load;
    logic sync_rst;
    logic [CNT_WIDTH-1:0] load_data;
    logic [CNT_WIDTH-1:0] value;
    logic at_terminal;

    modport ctrl (
        output up_dir,
        output load,
        output sync_rst,
        output load_data,
        input value,
        input at_terminal
    );

    modport core (
        input up_dir,
        input load,
        input sync_rst,
        input load_data,
        output value,
        output at_terminal
    );
endinterface
`default_nettype wire

// File: logic/cbc_counter_core.sv
// cbc_counter_core: the count register and its next-value selection
// assumes: controls are stable at each rising edge of aclk
`timescale 1ns/1ps
`default_nettype none
module cbc_counter_core
    import cbc_pkg::*;
#(
    parameter cbc_kind_t KIND = CBC_FREE,
    parameter cbc_dir_t DIR = CBC_UP,
    parameter bit HAS_LOAD = 1'b0,
    parameter logic [CNT_WIDTH-1:0] START = START_DEF,
    parameter logic [CNT_WIDTH-1:0] TERMINAL = TERMINAL_DEF,
    parameter logic [CNT_WIDTH-1:0] STEP = STEP_DEF
)
(
    input wire logic aclk,
    input wire logic aresetn,
    cbc_core_if.core cif
);

    // ************************************************
    // next value
    // ************************************************
    localparam bit LOAD_OK = HAS_LOAD && (KIND == CBC_FREE);
    localparam bit LIMITED = (KIND == CBC_LIMITED);

    logic [CNT_WIDTH-1:0] value_reg;
    logic [CNT_WIDTH-1:0] value_next;
    wire logic [CNT_WIDTH-1:0] sum_val = value_reg + STEP; // (R4)
    wire logic [CNT_WIDTH-1:0] diff_val = value_reg - STEP; // (R5)
    // (R6)
    wire logic add_sel = (DIR == CBC_UP) ? 1'b1 :
                         (DIR == CBC_DOWN) ? 1'b0 : cif.up_dir;
    wire logic [CNT_WIDTH-1:0] stepped = add_sel ? sum_val : diff_val; // (R10)
    // comparator beside a free running counter (R7)
    wire logic limit_hit = LIMITED && (value_reg == TERMINAL);
    wire logic rst_take = LOAD_OK && cif.sync_rst;
    wire logic load_take = LOAD_OK && cif.load;

    // restart beats load, load beats stepping (R11)
    assign value_next = rst_take ? START :
                        load_take ? cif.load_data : // (R3)
                        limit_hit ? START : // (R9)
                        stepped; // (R1)

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            value_reg <= START;
        else
            value_reg <= value_next;
    end

    assign cif.value = value_reg;
    assign cif.at_terminal = limit_hit;

endmodule // cbc_counter_core
`default_nettype wire

// File: logic/cbc_counter_top.sv
// cbc_counter_top: binary counter with an AXI4-Lite register file
// assumes: single clock aclk, synchronous active-low aresetn,
// an AXI4-Lite master with at most one write and one read in flight
//
// Operation
// (R1) The counter is built free running or count-limited, and up, down or run-time up/down.
// (R2) The count is an N-bit value read as signed or unsigned by a build option.
// (R3) With the load option, a free running counter shows the load data one cycle after load.
// (R4) A free running up counter starts at its start value, then adds the step modulo 2^N.
// (R5) A free running down counter subtracts the step modulo 2^N instead.
// (R6) In up/down mode the direction bit 1 adds the step and 0 subtracts it.
// (R7) A count-limited counter is a free running counter plus a comparator, at most 64 bits.
// (R8) Count-limited stepping works only when the step evenly divides terminal minus start.
// (R9) A count-limited up counter returns to start after showing the terminal value.
// (R10) A count-limited down counter subtracts; up/down follows the direction bit.
// (R11) In the loadable variant restart forces the start value over load, load over stepping.
// (R12) Terminal must differ from start; the unbounded setting means the largest value.
// (R13) Load data matches the count width and controls are stable at each clock edge.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cbc_counter_top
    import cbc_pkg::*;
#(
    parameter cbc_kind_t KIND = CBC_FREE,
    parameter cbc_dir_t DIR = CBC_UP,
    parameter bit IS_SIGNED = 1'b0,
    parameter bit HAS_LOAD = 1'b0,
    parameter bit TERM_INF = 1'b0,
    parameter logic [CNT_WIDTH-1:0] START = START_DEF,
    parameter logic [CNT_WIDTH-1:0] TERMINAL = TERMINAL_DEF,
    parameter logic [CNT_WIDTH-1:0] STEP = STEP_DEF
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [CNT_WIDTH-1:0] count_value
);

    // ************************************************
    // build-time derived values
    // ************************************************
    localparam bit LIMITED = (KIND == CBC_LIMITED);
    localparam bit LOAD_OK = HAS_LOAD && (KIND == CBC_FREE);
    // largest value at the chosen signedness (R12) (R2)
    localparam logic [CNT_WIDTH-1:0] TOP_VAL =
        IS_SIGNED ? {1'b0, {(CNT_WIDTH-1){1'b1}}} : {CNT_WIDTH{1'b1}};
    localparam logic [CNT_WIDTH-1:0] TERM_EFF =
        TERM_INF ? TOP_VAL : TERMINAL;
    localparam logic [CNT_WIDTH-1:0] SPAN_UP = TERM_EFF - START;
    localparam logic [CNT_WIDTH-1:0] SPAN_DN = START - TERM_EFF;

    // ************************************************
    // core
    // ************************************************
    cbc_core_if cif ();

    cbc_counter_core #(
        .KIND(KIND),
        .DIR(DIR),
        .HAS_LOAD(HAS_LOAD),
        .START(START),
        .TERMINAL(TERM_EFF),
        .STEP(STEP)
    ) u_core (
        .aclk(aclk),
        .aresetn(aresetn),
        .cif(cif.core)
    );

    assign count_value = cif.value;

    // ************************************************
    // write channel
    // ************************************************
    logic aw_got_reg;
    logic w_got_reg;
    logic [AXI_ADDR_W-1:0] awaddr_reg;
    logic [AXI_DATA_W-1:0] wdata_reg;
    logic [AXI_STRB_W-1:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = !w_got_reg && !bvalid_reg;
    wire logic aw_fire = s_axi_awvalid && s_axi_awready;
    wire logic w_fire = s_axi_wvalid && s_axi_wready;
    wire logic wr_go = (aw_got_reg || aw_fire) && (w_got_reg || w_fire);
    wire logic [AXI_ADDR_W-1:0] wr_addr =
        aw_got_reg ? awaddr_reg : s_axi_awaddr;
    wire logic [AXI_DATA_W-1:0] wr_data =
        w_got_reg ? wdata_reg : s_axi_wdata;
    wire logic [AXI_STRB_W-1:0] wr_strb =
        w_got_reg ? wstrb_reg : s_axi_wstrb;
    wire logic [AXI_ADDR_W-1:0] wr_word = {wr_addr[AXI_ADDR_W-1:2], 2'b00};

    // read-only words accept writes silently
    wire logic wr_ctrl = wr_go && (wr_word == OFF_CTRL);
    wire logic wr_ldat = wr_go && (wr_word == OFF_LOAD_DATA);
    wire logic wr_mapped = (wr_word == OFF_CTRL) ||
                           (wr_word == OFF_LOAD_DATA) ||
                           (wr_word == OFF_VALUE) ||
                           (wr_word == OFF_STATUS) ||
                           (wr_word == OFF_CONFIG);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            aw_got_reg <= 1'b0;
        else if (wr_go)
            aw_got_reg <= 1'b0;
        else if (aw_fire)
            aw_got_reg <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            w_got_reg <= 1'b0;
        else if (wr_go)
            w_got_reg <= 1'b0;
        else if (w_fire)
            w_got_reg <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (aw_fire)
            awaddr_reg <= s_axi_awaddr;
        if (w_fire)
            wdata_reg <= s_axi_wdata;
        if (w_fire)
            wstrb_reg <= s_axi_wstrb;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bvalid_reg <= 1'b0;
        else if (wr_go)
            bvalid_reg <= 1'b1;
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bresp_reg <= RESP_OKAY;
        else if (wr_go)
            bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ************************************************
    // control registers
    // ************************************************
    logic up_dir_reg;
    logic load_pulse_reg;
    logic rst_pulse_reg;
    logic [CNT_WIDTH-1:0] load_data_reg;

    wire logic ctrl_lane0 = wr_ctrl && wr_strb[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            up_dir_reg <= UP_DIR_RST;
        else if (ctrl_lane0)
            up_dir_reg <= wr_data[CTRL_UP_BIT];
    end

    // load and restart are one-cycle strobes, they read back as zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            load_pulse_reg <= 1'b0;
        else
            load_pulse_reg <= ctrl_lane0 && wr_data[CTRL_LOAD_BIT];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rst_pulse_reg <= 1'b0;
        else
            rst_pulse_reg <= ctrl_lane0 && wr_data[CTRL_RESTART_BIT];
    end

    genvar gi;
    generate
        for (gi = 0; gi < AXI_STRB_W; gi++)
        begin : g_ldat
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    load_data_reg[gi*8 +: 8] <= 8'h00;
                else if (wr_ldat && wr_strb[gi])
                    load_data_reg[gi*8 +: 8] <= wr_data[gi*8 +: 8];
            end
        end
    endgenerate

    assign cif.up_dir = up_dir_reg; // (R6)
    assign cif.load = load_pulse_reg; // (R3)
    assign cif.sync_rst = rst_pulse_reg; // (R11)
    assign cif.load_data = load_data_reg;

    // ************************************************
    // read channel
    // ************************************************
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [AXI_DATA_W-1:0] rdata_reg;

    assign s_axi_arready = !rvalid_reg;
    wire logic ar_fire = s_axi_arvalid && s_axi_arready;
    wire logic [AXI_ADDR_W-1:0] rd_word =
        {s_axi_araddr[AXI_ADDR_W-1:2], 2'b00};

    wire logic [AXI_DATA_W-1:0] ctrl_word =
        AXI_DATA_W'(up_dir_reg) << CTRL_UP_BIT;
    wire logic [AXI_DATA_W-1:0] stat_word =
        (AXI_DATA_W'(cif.at_terminal) << STAT_TERM_BIT) |
        (AXI_DATA_W'(up_dir_reg) << STAT_DIR_BIT);
    // lets software learn how to read the count (R2)
    wire logic [AXI_DATA_W-1:0] cfg_word =
        (AXI_DATA_W'(LIMITED) << CFG_LIMITED_BIT) |
        (AXI_DATA_W'(IS_SIGNED) << CFG_SIGNED_BIT) |
        (AXI_DATA_W'(LOAD_OK) << CFG_LOAD_BIT) |
        (AXI_DATA_W'(DIR) << CFG_DIR_LSB);

    wire logic rd_mapped = (rd_word == OFF_CTRL) ||
                           (rd_word == OFF_LOAD_DATA) ||
                           (rd_word == OFF_VALUE) ||
                           (rd_word == OFF_STATUS) ||
                           (rd_word == OFF_CONFIG);
    wire logic [AXI_DATA_W-1:0] rd_mux =
        (rd_word == OFF_CTRL) ? ctrl_word :
        (rd_word == OFF_LOAD_DATA) ? load_data_reg :
        (rd_word == OFF_VALUE) ? cif.value :
        (rd_word == OFF_STATUS) ? stat_word :
        (rd_word == OFF_CONFIG) ? cfg_word : 32'h0000_0000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rvalid_reg <= 1'b0;
        else if (ar_fire)
            rvalid_reg <= 1'b1;
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end
        else if (ar_fire)
        begin
            rdata_reg <= rd_mux;
            rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // a strobe that really overrides stepping this cycle
    wire logic ovr = LOAD_OK && (cif.sync_rst || cif.load);
    wire logic plain = !ovr && !cif.at_terminal;

    chk_reset_start: assert property ( // (R4)
        !$past(aresetn) |-> cif.value == START)
        else $error("count did not start at start value");

    chk_free_up: assert property ( // (R4)
        (KIND == CBC_FREE) && aresetn && plain && ((DIR == CBC_UP) ||
        ((DIR == CBC_UPDOWN) && cif.up_dir))
        |=> cif.value == $past(cif.value) + STEP)
        else $error("free up count did not add step");

    chk_free_down: assert property ( // (R5)
        (KIND == CBC_FREE) && aresetn && plain && ((DIR == CBC_DOWN) ||
        ((DIR == CBC_UPDOWN) && !cif.up_dir))
        |=> cif.value == $past(cif.value) - STEP)
        else $error("free down count did not subtract step");

    chk_dir_select: assert property ( // (R6)
        (DIR == CBC_UPDOWN) && plain ##1 !$stable(cif.up_dir) ##0
        (!ovr && !cif.at_terminal)
        |=> cif.value == ($past(cif.up_dir) ?
            $past(cif.value) + STEP : $past(cif.value) - STEP))
        else $error("up/down step does not follow direction");

    chk_load_take: assert property ( // (R3)
        LOAD_OK && cif.load && !cif.sync_rst
        |=> cif.value == $past(cif.load_data))
        else $error("load data not shown one cycle after load");

    chk_rst_first: assert property ( // (R11)
        LOAD_OK && cif.sync_rst ##1 1'b1 |-> cif.value == START)
        else $error("restart did not win over load");

    chk_limit_restart: assert property ( // (R9)
        LIMITED && (cif.value == TERM_EFF) |=> cif.value == START)
        else $error("limited count did not return to start");

    chk_limit_down: assert property ( // (R10)
        LIMITED && aresetn && !cif.at_terminal && ((DIR == CBC_DOWN) ||
        ((DIR == CBC_UPDOWN) && !cif.up_dir))
        |=> cif.value == $past(cif.value) - STEP)
        else $error("limited down count did not subtract step");

    chk_width_cap: assert property ( // (R7)
        !LIMITED || (CNT_WIDTH <= CNT_WIDTH_MAX))
        else $error("limited counter wider than 64 bits");

    chk_term_distinct: assert property ( // (R12)
        !LIMITED || (TERM_EFF != START))
        else $error("terminal value equals start value");

    chk_step_divides: assert property ( // (R8)
        !LIMITED || ((SPAN_UP % STEP) == 0) || ((SPAN_DN % STEP) == 0))
        else $error("step does not divide the count span");

    cov_load: cover property (LOAD_OK && cif.load ##1 1'b1);
    cov_terminal: cover property (cif.at_terminal ##1 !cif.at_terminal);
    cov_dir_flip: cover property (cif.up_dir ##1 !cif.up_dir);
    cov_write_read: cover property (wr_go ##[1:20] ar_fire);

endmodule // cbc_counter_top
`default_nettype wire

// File: verif/cbc_axi_master.sv
// cbc_axi_master: AXI4-Lite master standing in for the surrounding logic
// assumes: one caller at a time; payload changes only after a clock edge
`timescale 1ns/1ps
`default_nettype none
module cbc_axi_master
    import cbc_pkg::*;
(
    input wire logic aclk,
    output var logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    output var logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output var logic [AXI_DATA_W-1:0] s_axi_wdata,
    output var logic [AXI_STRB_W-1:0] s_axi_wstrb,
    output var logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output var logic s_axi_bready,
    output var logic [AXI_ADDR_W-1:0] s_axi_araddr,
    output var logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output var logic s_axi_rready
);
    // ************************************************
    // idle levels and transfer tasks
    // ************************************************
    initial
    begin
        s_axi_awaddr = 5'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 5'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end

    // full-width word, held unchanged until its own ready edge
    task automatic axi_write(input logic [AXI_ADDR_W-1:0] addr,
        input logic [AXI_DATA_W-1:0] data, output logic [1:0] resp);
        bit aw_done;
        bit w_done;
        bit b_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_done)
        begin
            @(posedge aclk);
            if (aw_done && w_done && s_axi_bvalid)
            begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                b_done = 1'b1;
            end
            // released lines show garbage, not the old payload
            if (!aw_done && s_axi_awready)
            begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~addr;
                aw_done = 1'b1;
            end
            if (!w_done && s_axi_wready)
            begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~data;
                w_done = 1'b1;
            end
        end
    endtask

    task automatic axi_read(input logic [AXI_ADDR_W-1:0] addr,
        output logic [AXI_DATA_W-1:0] data, output logic [1:0] resp);
        bit ar_done;
        bit r_done;
        ar_done = 1'b0;
        r_done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_done)
        begin
            @(posedge aclk);
            if (ar_done && s_axi_rvalid)
            begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                r_done = 1'b1;
            end
            if (!ar_done && s_axi_arready)
            begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~addr;
                ar_done = 1'b1;
            end
        end
    endtask
endmodule // cbc_axi_master
`default_nettype wire

// File: verif/tb_top.sv
// tb_top: self-checking bench, a loadable free build and a limited build
// assumes: package and design files compiled first; both share one bus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cbc_pkg::*;
    // ************************************************
    // builds and signals
    // ************************************************
    localparam logic [CNT_WIDTH-1:0] A_START = 32'h0000_0100;
    localparam logic [CNT_WIDTH-1:0] A_STEP = 32'h0000_0003;
    localparam logic [CNT_WIDTH-1:0] B_START = 32'h0000_0002;
    localparam logic [CNT_WIDTH-1:0] B_TERM = 32'h0000_000E;
    localparam logic [CNT_WIDTH-1:0] B_STEP = 32'h0000_0003;
    typedef struct {
        logic [AXI_DATA_W-1:0] ctrl;
        logic [AXI_DATA_W-1:0] ld;
        int wait_n;
        logic [CNT_WIDTH-1:0] want;
    } cbc_row_t;
    cbc_row_t rows [7];
    logic aclk;
    logic aresetn;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [AXI_STRB_W-1:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [CNT_WIDTH-1:0] cnt_a, cnt_b;
    int fails;
    int checks_done;

    cbc_axi_master u_cbc_axi_master (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    cbc_counter_top #(.KIND(CBC_FREE), .DIR(CBC_UPDOWN), .IS_SIGNED(1'b1),
        .HAS_LOAD(1'b1), .START(A_START), .STEP(A_STEP)) u_cbc_counter_top (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .count_value(cnt_a)
    );
    // limited build listens to the same bus; its answers go unused
    cbc_counter_top #(.KIND(CBC_LIMITED), .DIR(CBC_UPDOWN), .START(B_START),
        .TERMINAL(B_TERM), .STEP(B_STEP)) u_cbc_counter_top_lim (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(),
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(),
        .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
        .s_axi_rvalid(), .s_axi_rready, .count_value(cnt_b)
    );
    // ************************************************
    // compares and bus helpers
    // ************************************************
    task automatic chk_val(input logic [AXI_DATA_W-1:0] got, exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("BAD %0t value %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("BAD %0t resp %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [AXI_ADDR_W-1:0] addr,
        input logic [AXI_DATA_W-1:0] mask, exp, input logic [1:0] eresp);
        logic [AXI_DATA_W-1:0] data;
        logic [1:0] resp;
        u_cbc_axi_master.axi_read(addr, data, resp);
        chk_resp(resp, eresp);
        chk_val(data & mask, exp);
    endtask
    task automatic wr_chk(input logic [AXI_ADDR_W-1:0] addr,
        input logic [AXI_DATA_W-1:0] data, input logic [1:0] eresp);
        logic [1:0] resp;
        u_cbc_axi_master.axi_write(addr, data, resp);
        chk_resp(resp, eresp);
    endtask
    task automatic give_verdict;
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ************************************************
    // clock, watchdog, sequence
    // ************************************************
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial
    begin
        #200000;
        fails = fails + 1;
        give_verdict;
    end
    initial
    begin
        // ctrl (bit0 up, bit1 load, bit2 restart), load data, wait, count
        rows[0] = '{32'h0000_0003, 32'h0000_0010, 5, 32'h0000_001F};
        rows[1] = '{32'h0000_0002, 32'h0000_0005, 3, 32'hFFFF_FFFC};
        rows[2] = '{32'h0000_0003, 32'hFFFF_FFFE, 1, 32'h0000_0001};
        rows[3] = '{32'h0000_0007, 32'h0000_0077, 2, 32'h0000_0106};
        rows[4] = '{32'h0000_0004, 32'h0000_0000, 0, 32'h0000_0100};
        rows[5] = '{32'h0000_0006, 32'h0000_0055, 2, 32'h0000_00FA};
        rows[6] = '{32'h0000_0001, 32'h0000_0000, 0, 32'h0000_00EE};
    end
    initial
    begin
        aresetn = 1'b0;
        fails = 0;
        checks_done = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        for (int k = 0; k < 12; k++)
        begin
            chk_val(cnt_a, A_START + A_STEP * k);
            chk_val(cnt_b, B_START + B_STEP * (k % 5));
            @(posedge aclk);
            #1;
        end
        rd_chk(OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0001, RESP_OKAY);
        rd_chk(OFF_LOAD_DATA, 32'hFFFF_FFFF, 32'h0000_0000, RESP_OKAY);
        rd_chk(OFF_STATUS, 32'h0000_0002, 32'h0000_0002, RESP_OKAY);
        rd_chk(OFF_CONFIG, 32'hFFFF_FFFF, 32'h0000_0026, RESP_OKAY);
        rd_chk(5'h14, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR);
        wr_chk(5'h18, 32'h0000_0001, RESP_SLVERR);
        wr_chk(OFF_CONFIG, 32'h0000_0000, RESP_OKAY);
        rd_chk(OFF_CONFIG, 32'hFFFF_FFFF, 32'h0000_0026, RESP_OKAY);
        foreach (rows[i])
        begin
            wr_chk(OFF_LOAD_DATA, rows[i].ld, RESP_OKAY);
            wr_chk(OFF_CTRL, rows[i].ctrl, RESP_OKAY);
            repeat (rows[i].wait_n) @(posedge aclk);
            #1;
            chk_val(cnt_a, rows[i].want);
        end
        // strobes read back as zero, up bit stays as written
        rd_chk(OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0001, RESP_OKAY);
        rd_chk(OFF_STATUS, 32'h0000_0002, 32'h0000_0002, RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
        chk_val(cnt_a, A_START);
        chk_val(cnt_b, B_START);
        @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0001, RESP_OKAY);
        rd_chk(OFF_LOAD_DATA, 32'hFFFF_FFFF, 32'h0000_0000, RESP_OKAY);
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
